// ---- src/ppb_pkg.sv ----
package ppb_pkg;
	// bus widths
	localparam int DATA_W = 32;
	localparam int REPORT_W = 8;
	// transmit buffer: depth in words, fill level counted in words
	localparam int TX_DEPTH = 64;
	localparam int TX_PTR_W = 6;
	localparam int TX_LVL_W = 7;
	// word stored in transmit buffer: {sop, eop, data}
	localparam int TX_WORD_W = DATA_W + 2;
	localparam int TX_SOP_BIT = DATA_W + 1;
	localparam int TX_EOP_BIT = DATA_W;
	// idle link clocks between packets
	localparam logic [1:0] GAP_CYCLES = 2'h2;
	// input sampling chain length
	localparam int SYNC_STAGES = 3;
	// sampled pin vector layout
	localparam int PIN_W = DATA_W + 7;
	localparam int PIN_DATA_LSB = 0;
	localparam int PIN_TX_EOP = DATA_W;
	localparam int PIN_TX_SOP = DATA_W + 1;
	localparam int PIN_TX_WE_B = DATA_W + 2;
	localparam int PIN_RX_EN_B = DATA_W + 3;
	localparam int PIN_REP_EN_B = DATA_W + 4;
	localparam int PIN_TX_CLK = DATA_W + 5;
	localparam int PIN_RX_CLK = DATA_W + 6;
	localparam int PIN_REP_CLK_BIT = 0;
	// reset values
	localparam logic TX_AVAIL_RST = 1'b1;
	localparam logic [1:0] PIN_SYNC_RST = 2'h3;
	// sender states, one-hot
	typedef enum logic [2:0]
	{
		PPB_IDLE = 3'b001,
		PPB_XFER = 3'b010,
		PPB_GAP = 3'b100
	} ppb_rx_state_type;
endpackage

// ---- src/ppb_rx_port.sv ----
`timescale 1ns/1ps
`default_nettype none
// drives one receive-style packet bus (data or report) on link clock edges
module ppb_rx_port #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// sampled link side
	input wire logic link_rise,
	input wire logic read_enable_b,
	input wire logic registered_mode,
	// word source
	input wire logic [W-1:0] src_data,
	input wire logic src_sop,
	input wire logic src_eop,
	input wire logic src_valid,
	output logic src_take,
	// bus pins
	output logic [W-1:0] bus_data,
	output logic bus_sop,
	output logic bus_eop,
	output logic bus_valid,
	output logic bus_avail,
	output logic bus_oe,
	output logic avail_oe
);
	ppb_pkg::ppb_rx_state_type state_reg;
	logic en_prev_b_reg;
	logic [1:0] gap_reg;
	logic en_active;
	logic take_now;

	// alternate mode uses the enable seen one link clock earlier
	assign en_active = registered_mode ? !en_prev_b_reg : !read_enable_b;
	assign take_now = link_rise && en_active && src_valid
		&& (state_reg != ppb_pkg::PPB_GAP);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			en_prev_b_reg <= 1'b1;
		else if (link_rise)
			en_prev_b_reg <= read_enable_b;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			src_take <= 1'b0;
		else
			src_take <= take_now;
	end

	// outputs float while in reset; after release the bus is driven, cell available only in registered mode
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_oe <= 1'b0;
			avail_oe <= 1'b0;
		end
		else
		begin
			bus_oe <= 1'b1;
			avail_oe <= registered_mode;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			bus_avail <= 1'b0;
		else if (link_rise)
			bus_avail <= src_valid && (state_reg != ppb_pkg::PPB_GAP);
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= ppb_pkg::PPB_IDLE;
			gap_reg <= 2'h0;
			bus_data <= '0;
			bus_sop <= 1'b0;
			bus_eop <= 1'b0;
			bus_valid <= 1'b0;
		end
		else if (link_rise)
		begin
			case (state_reg)
				ppb_pkg::PPB_IDLE:
				begin
					// outside a packet outputs follow the next clock
					bus_valid <= take_now;
					bus_data <= src_data;
					bus_sop <= take_now && src_sop;
					bus_eop <= take_now && src_eop;
					if (take_now)
					begin
						gap_reg <= 2'h0;
						state_reg <= src_eop ? ppb_pkg::PPB_GAP : ppb_pkg::PPB_XFER;
					end
				end
				ppb_pkg::PPB_XFER:
				begin
					// disabled mid-packet: hold the previous outputs
					if (en_active)
					begin
						bus_valid <= take_now;
						bus_data <= src_data;
						bus_sop <= take_now && src_sop;
						bus_eop <= take_now && src_eop;
						if (take_now && src_eop)
						begin
							gap_reg <= 2'h0;
							state_reg <= ppb_pkg::PPB_GAP;
						end
					end
				end
				ppb_pkg::PPB_GAP:
				begin
					bus_valid <= 1'b0;
					bus_sop <= 1'b0;
					bus_eop <= 1'b0;
					gap_reg <= gap_reg + 2'h1;
					if (gap_reg + 2'h1 == ppb_pkg::GAP_CYCLES)
						state_reg <= ppb_pkg::PPB_IDLE;
				end
				default:
					state_reg <= ppb_pkg::PPB_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- src/ppb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppb_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// configuration
	input wire logic registered_mode,
	input wire logic [ppb_pkg::TX_LVL_W-1:0] tx_thresh_upper,
	input wire logic [ppb_pkg::TX_LVL_W-1:0] tx_thresh_lower,
	// transmit bus pins
	input wire logic tx_link_clk,
	input wire logic tx_write_enable_b,
	input wire logic [ppb_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_sop,
	input wire logic tx_eop,
	output logic tx_pkt_avail,
	output logic tx_pkt_avail_oe,
	// transmit words to the device core
	output logic [ppb_pkg::DATA_W-1:0] tx_out_data,
	output logic tx_out_sop,
	output logic tx_out_eop,
	output logic tx_out_valid,
	input wire logic tx_out_ready,
	output logic tx_overflow,
	// receive bus pins
	input wire logic rx_link_clk,
	input wire logic rx_read_enable_b,
	output logic [ppb_pkg::DATA_W-1:0] rx_data,
	output logic rx_sop,
	output logic rx_eop,
	output logic rx_valid,
	output logic rx_cell_avail,
	output logic rx_oe,
	output logic rx_cell_avail_oe,
	// receive words from the device core
	input wire logic [ppb_pkg::DATA_W-1:0] rx_in_data,
	input wire logic rx_in_sop,
	input wire logic rx_in_eop,
	input wire logic rx_in_valid,
	output logic rx_in_take,
	// report bus pins
	input wire logic rep_link_clk,
	input wire logic report_read_enable_b,
	output logic [ppb_pkg::REPORT_W-1:0] rep_data,
	output logic rep_sop,
	output logic rep_eop,
	output logic rep_valid,
	output logic rep_cell_avail,
	output logic rep_oe,
	output logic rep_cell_avail_oe,
	// report words from the device core
	input wire logic [ppb_pkg::REPORT_W-1:0] rep_in_data,
	input wire logic rep_in_sop,
	input wire logic rep_in_eop,
	input wire logic rep_in_valid,
	output logic rep_in_take
);
	logic [ppb_pkg::PIN_W-1:0] pins;
	logic [ppb_pkg::PIN_W-1:0] s1_reg;
	logic [ppb_pkg::PIN_W-1:0] s2_reg;
	logic [ppb_pkg::PIN_W-1:0] s3_reg;
	logic [ppb_pkg::PIN_W-1:0] seen_reg;
	logic [ppb_pkg::PIN_W-1:0] seen_next;
	logic rclk_s1_reg;
	logic rclk_s2_reg;
	logic rclk_s3_reg;
	logic rep_clk_seen_reg;
	logic tx_rise;
	logic rx_rise;
	logic rep_rise;

	logic [ppb_pkg::TX_WORD_W-1:0] tx_mem [0:ppb_pkg::TX_DEPTH-1];
	logic [ppb_pkg::TX_PTR_W-1:0] wr_ptr_reg;
	logic [ppb_pkg::TX_PTR_W-1:0] rd_ptr_reg;
	logic [ppb_pkg::TX_LVL_W-1:0] fill_reg;
	logic tx_full;
	logic tx_push;
	logic tx_pop;
	logic [ppb_pkg::TX_WORD_W-1:0] tx_word;

	assign pins = {rx_link_clk, tx_link_clk, report_read_enable_b,
		rx_read_enable_b, tx_write_enable_b, tx_sop, tx_eop, tx_data};

	// three-stage sampling of every pin; a level counts once stages 2 and 3 agree
	genvar i;
	generate
		for (i = 0; i < ppb_pkg::PIN_W; i++)
		begin : g_pin
			always_ff @(posedge ref_clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					s1_reg[i] <= 1'b0;
					s2_reg[i] <= 1'b0;
					s3_reg[i] <= 1'b0;
					seen_reg[i] <= 1'b0;
				end
				else
				begin
					s1_reg[i] <= pins[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
					seen_reg[i] <= seen_next[i];
				end
			end
			assign seen_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : seen_reg[i];
		end
	endgenerate

	// report link clock kept apart so the vector stays a single width
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rclk_s1_reg <= 1'b0;
			rclk_s2_reg <= 1'b0;
			rclk_s3_reg <= 1'b0;
			rep_clk_seen_reg <= 1'b0;
		end
		else
		begin
			rclk_s1_reg <= rep_link_clk;
			rclk_s2_reg <= rclk_s1_reg;
			rclk_s3_reg <= rclk_s2_reg;
			if (rclk_s2_reg == rclk_s3_reg)
				rep_clk_seen_reg <= rclk_s3_reg;
		end
	end

	assign tx_rise = seen_next[ppb_pkg::PIN_TX_CLK]
		&& !seen_reg[ppb_pkg::PIN_TX_CLK];
	assign rx_rise = seen_next[ppb_pkg::PIN_RX_CLK]
		&& !seen_reg[ppb_pkg::PIN_RX_CLK];
	assign rep_rise = (rclk_s2_reg == rclk_s3_reg)
		&& rclk_s3_reg && !rep_clk_seen_reg;

	// transmit bus: system writes fragments into the buffer
	assign tx_full = (fill_reg == ppb_pkg::TX_LVL_W'(ppb_pkg::TX_DEPTH));
	assign tx_push = tx_rise && !seen_next[ppb_pkg::PIN_TX_WE_B] && !tx_full;
	assign tx_pop = (fill_reg != '0) && (!tx_out_valid || tx_out_ready);
	assign tx_word = tx_mem[rd_ptr_reg];

	// fragment marks travel with each word unchanged
	always_ff @(posedge ref_clk)
	begin
		if (tx_push)
			tx_mem[wr_ptr_reg] <= {seen_next[ppb_pkg::PIN_TX_SOP],
				seen_next[ppb_pkg::PIN_TX_EOP],
				seen_next[ppb_pkg::DATA_W-1:ppb_pkg::PIN_DATA_LSB]};
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg <= '0;
		end
		else
		begin
			if (tx_push)
				wr_ptr_reg <= wr_ptr_reg + ppb_pkg::TX_PTR_W'(1);
			if (tx_pop)
				rd_ptr_reg <= rd_ptr_reg + ppb_pkg::TX_PTR_W'(1);
			if (tx_push && !tx_pop)
				fill_reg <= fill_reg + ppb_pkg::TX_LVL_W'(1);
			else if (tx_pop && !tx_push)
				fill_reg <= fill_reg - ppb_pkg::TX_LVL_W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_out_valid <= 1'b0;
			tx_out_data <= '0;
			tx_out_sop <= 1'b0;
			tx_out_eop <= 1'b0;
		end
		else if (tx_pop)
		begin
			tx_out_valid <= 1'b1;
			tx_out_data <= tx_word[ppb_pkg::DATA_W-1:0];
			tx_out_sop <= tx_word[ppb_pkg::TX_SOP_BIT];
			tx_out_eop <= tx_word[ppb_pkg::TX_EOP_BIT];
		end
		else if (tx_out_ready)
			tx_out_valid <= 1'b0;
	end

	// a write with no room is dropped and flagged for one clock
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			tx_overflow <= 1'b0;
		else
			tx_overflow <= tx_rise && !seen_next[ppb_pkg::PIN_TX_WE_B] && tx_full;
	end

	// hysteresis on packet-available, checked every clock
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			tx_pkt_avail <= ppb_pkg::TX_AVAIL_RST;
		else if (tx_full || fill_reg > tx_thresh_upper)
			tx_pkt_avail <= 1'b0;
		else if (fill_reg < tx_thresh_lower)
			tx_pkt_avail <= 1'b1;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			tx_pkt_avail_oe <= 1'b0;
		else
			tx_pkt_avail_oe <= 1'b1;
	end

	// receive data bus, device to system
	ppb_rx_port #(
		.W(ppb_pkg::DATA_W)
	) u_rx (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.link_rise(rx_rise),
		.read_enable_b(seen_next[ppb_pkg::PIN_RX_EN_B]),
		.registered_mode(registered_mode),
		.src_data(rx_in_data),
		.src_sop(rx_in_sop),
		.src_eop(rx_in_eop),
		.src_valid(rx_in_valid),
		.src_take(rx_in_take),
		.bus_data(rx_data),
		.bus_sop(rx_sop),
		.bus_eop(rx_eop),
		.bus_valid(rx_valid),
		.bus_avail(rx_cell_avail),
		.bus_oe(rx_oe),
		.avail_oe(rx_cell_avail_oe)
	);

	// report bus uses the same sender, 8 bits wide
	ppb_rx_port #(
		.W(ppb_pkg::REPORT_W)
	) u_rep (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.link_rise(rep_rise),
		.read_enable_b(seen_next[ppb_pkg::PIN_REP_EN_B]),
		.registered_mode(registered_mode),
		.src_data(rep_in_data),
		.src_sop(rep_in_sop),
		.src_eop(rep_in_eop),
		.src_valid(rep_in_valid),
		.src_take(rep_in_take),
		.bus_data(rep_data),
		.bus_sop(rep_sop),
		.bus_eop(rep_eop),
		.bus_valid(rep_valid),
		.bus_avail(rep_cell_avail),
		.bus_oe(rep_oe),
		.avail_oe(rep_cell_avail_oe)
	);
endmodule
`default_nettype wire

// ---- sim/ppb_sys_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// system side: link clock, transmit writer, read enables, bus capture
module ppb_sys_model (
	// link pins toward the block
	output var logic link_clk,
	output var logic tx_write_enable_b,
	output var logic [31:0] tx_data,
	output var logic tx_sop,
	output var logic tx_eop,
	output var logic en_b,
	// receive and report pins from the block
	input wire logic registered_mode,
	input wire logic [31:0] rx_data,
	input wire logic rx_sop,
	input wire logic rx_eop,
	input wire logic rx_valid,
	input wire logic [7:0] rep_data,
	input wire logic rep_sop,
	input wire logic rep_eop,
	input wire logic rep_valid
);
	logic [7:0] en_pat = 8'h00;
	logic [1:0] en_hist = 2'h3;
	logic use_b;
	logic [33:0] rxq[$];
	logic [33:0] rpq[$];
	int tx_cnt = 0;
	int k = 0;
	assign use_b = registered_mode ? en_hist[1] : en_hist[0];
	initial
	begin
		tx_write_enable_b = 1'b1;
		tx_data = 32'h0;
		tx_sop = 1'b0;
		tx_eop = 1'b0;
		en_b = 1'b1;
		link_clk = 1'b0;
		forever #100 link_clk = ~link_clk;
	end
	// a word counts only when the enable was low a clock before, two clocks before in registered mode
	always @(posedge link_clk)
	begin
		if (!use_b && rx_valid)
			rxq.push_back({rx_sop, rx_eop, rx_data});
		if (!use_b && rep_valid)
			rpq.push_back({rep_sop, rep_eop, 24'h0, rep_data});
		en_hist <= {en_hist[0], en_b};
	end
	always @(negedge link_clk)
	begin
		en_b <= en_pat[k];
		k <= (k + 1) % 8;
	end
	task automatic send_tx(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge link_clk);
			tx_write_enable_b <= 1'b0;
			tx_data <= 32'(32'ha000 + tx_cnt);
			tx_sop <= (i == 0);
			tx_eop <= (i == n - 1);
			tx_cnt++;
		end
		@(negedge link_clk);
		tx_write_enable_b <= 1'b1;
		// released lines show the inverse so stale data cannot pass
		tx_data <= ~tx_data;
	endtask
endmodule
`default_nettype wire

// ---- sim/ppb_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppb_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// transmit side
	input wire logic registered_mode,
	input wire logic tx_pkt_avail,
	input wire logic tx_pkt_avail_oe,
	input wire logic [ppb_pkg::DATA_W-1:0] tx_out_data,
	input wire logic tx_out_valid,
	input wire logic tx_out_ready,
	input wire logic tx_overflow,
	// receive and report side
	input wire logic [ppb_pkg::DATA_W-1:0] rx_data,
	input wire logic rx_sop,
	input wire logic rx_eop,
	input wire logic rx_valid,
	input wire logic rx_oe,
	input wire logic rx_cell_avail_oe,
	input wire logic [ppb_pkg::DATA_W-1:0] rx_in_data,
	input wire logic rx_in_sop,
	input wire logic rx_in_eop,
	input wire logic rx_in_valid,
	input wire logic rx_in_take,
	input wire logic [ppb_pkg::REPORT_W-1:0] rep_data,
	input wire logic rep_valid,
	input wire logic rep_oe,
	input wire logic [ppb_pkg::REPORT_W-1:0] rep_in_data,
	input wire logic rep_in_take
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	logic [4:0] since_eop_reg;
	// link clock is eight reference clocks: two idle link clocks put the
	// next take at least sixteen clocks after an end word
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			since_eop_reg <= 5'h1f;
		else if (rx_in_take && rx_in_eop)
			since_eop_reg <= 5'h00;
		else if (since_eop_reg != 5'h1f)
			since_eop_reg <= since_eop_reg + 5'h01;
	end
	float_reset_a: assert property (disable iff (1'b0)
		!rst_b |-> !rx_oe && !rep_oe && !tx_pkt_avail_oe && !rx_valid)
		else $error("bus outputs driven in reset");
	full_avail_a: assert property (tx_overflow |-> !tx_pkt_avail)
		else $error("available high while buffer full");
	cell_oe_a: assert property (1'b1 |=>
		rx_cell_avail_oe == $past(registered_mode))
		else $error("cell available drive does not follow mode");
	take_valid_a: assert property (rx_in_take |-> rx_in_valid)
		else $error("word taken while none offered");
	rx_word_a: assert property (rx_in_take |-> rx_valid &&
		rx_data == rx_in_data && {rx_sop, rx_eop} == {rx_in_sop, rx_in_eop})
		else $error("receive bus word differs from word taken");
	rep_word_a: assert property (rep_in_take |-> rep_valid &&
		rep_data == rep_in_data)
		else $error("report bus word differs from word taken");
	rx_gap_a: assert property (
		rx_in_take |-> since_eop_reg >= 5'h10)
		else $error("packets too close on receive bus");
	tx_hold_a: assert property (tx_out_valid && !tx_out_ready |=>
		tx_out_valid && $stable(tx_out_data))
		else $error("transmit word lost before taken");
endmodule
bind ppb_top ppb_chk chk (.ref_clk, .rst_b, .registered_mode, .tx_pkt_avail,
	.tx_pkt_avail_oe, .tx_out_data, .tx_out_valid, .tx_out_ready,
	.tx_overflow, .rx_data, .rx_sop, .rx_eop, .rx_valid, .rx_oe,
	.rx_cell_avail_oe, .rx_in_data, .rx_in_sop, .rx_in_eop, .rx_in_valid,
	.rx_in_take, .rep_data, .rep_valid, .rep_oe, .rep_in_data, .rep_in_take);
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk, rst_b, registered_mode, tx_out_ready;
	logic [6:0] tx_thresh_upper, tx_thresh_lower;
	logic link_clk, tx_write_enable_b, tx_sop, tx_eop, en_b;
	logic [31:0] tx_data, tx_out_data, rx_data, rx_in_data;
	logic tx_pkt_avail, tx_pkt_avail_oe, tx_out_sop, tx_out_eop;
	logic tx_out_valid, tx_overflow, rx_sop, rx_eop, rx_valid;
	logic rx_cell_avail, rx_oe, rx_cell_avail_oe, rx_in_take;
	logic rx_in_sop, rx_in_eop, rx_in_valid, rep_in_sop, rep_in_eop;
	logic rep_in_valid, rep_in_take, rep_sop, rep_eop, rep_valid;
	logic rep_cell_avail, rep_oe, rep_cell_avail_oe;
	logic rx_tk = 1'b0, rp_tk = 1'b0;
	logic [7:0] rep_data, rep_in_data;
	int err_count = 0, num_checks = 0, tx_exp = 0;
	int rx_idx = 0, rp_idx = 0, rx_lim = 0, rp_lim = 0;
	int ovf_count = 0;
	ppb_top uut (.ref_clk, .rst_b, .registered_mode, .tx_thresh_upper,
		.tx_thresh_lower, .tx_link_clk(link_clk), .tx_write_enable_b,
		.tx_data, .tx_sop, .tx_eop, .tx_pkt_avail, .tx_pkt_avail_oe,
		.tx_out_data, .tx_out_sop, .tx_out_eop, .tx_out_valid, .tx_out_ready,
		.tx_overflow, .rx_link_clk(link_clk), .rx_read_enable_b(en_b),
		.rx_data, .rx_sop, .rx_eop, .rx_valid, .rx_cell_avail, .rx_oe,
		.rx_cell_avail_oe, .rx_in_data, .rx_in_sop, .rx_in_eop, .rx_in_valid,
		.rx_in_take, .rep_link_clk(link_clk), .report_read_enable_b(en_b),
		.rep_data, .rep_sop, .rep_eop, .rep_valid, .rep_cell_avail, .rep_oe,
		.rep_cell_avail_oe, .rep_in_data, .rep_in_sop, .rep_in_eop,
		.rep_in_valid, .rep_in_take);
	ppb_sys_model sys (.link_clk, .tx_write_enable_b, .tx_data, .tx_sop,
		.tx_eop, .en_b, .registered_mode, .rx_data, .rx_sop, .rx_eop,
		.rx_valid, .rep_data, .rep_sop, .rep_eop, .rep_valid);
	// core sources: packets of three receive words, two report words
	assign rx_in_data = 32'(32'h100 + rx_idx);
	assign rx_in_sop = rx_idx % 3 == 0;
	assign rx_in_eop = rx_idx % 3 == 2;
	assign rx_in_valid = rx_idx < rx_lim;
	assign rep_in_data = 8'(8'h40 + rp_idx);
	assign rep_in_sop = rp_idx % 2 == 0;
	assign rep_in_eop = rp_idx % 2 == 1;
	assign rep_in_valid = rp_idx < rp_lim;
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// word moves on one clock after its take pulse
	always @(negedge ref_clk)
	begin
		rx_tk <= rx_in_take;
		rp_tk <= rep_in_take;
		rx_idx <= rx_idx + rx_tk;
		rp_idx <= rp_idx + rp_tk;
		ovf_count <= ovf_count + (tx_overflow === 1'b1);
	end
	task automatic print_verdict;
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk1(input logic seen, input logic exp);
		check({33'h0, seen}, {33'h0, exp});
	endtask
	task automatic hang;
		err_count++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		print_verdict();
	endtask
	task automatic pop(input int n);
		for (int i = 0; i < n; i++)
		begin
			for (int t = 0; tx_out_valid !== 1'b1; t++)
			begin
				if (t == 400)
					hang();
				@(negedge ref_clk);
			end
			// flow_scn sends packets of six and then four words
			check({tx_out_sop, tx_out_eop, tx_out_data},
				{tx_exp == 0 || tx_exp == 6, tx_exp == 5 || tx_exp == 9,
				32'(32'ha000 + tx_exp)});
			tx_exp++;
			tx_out_ready = 1'b1;
			@(negedge ref_clk);
			tx_out_ready = 1'b0;
			@(negedge ref_clk);
		end
	endtask
	task automatic flow_scn;
		sys.send_tx(6);
		repeat (8) @(negedge ref_clk);
		chk1(tx_pkt_avail, 1'b1);
		sys.send_tx(4);
		repeat (8) @(negedge ref_clk);
		chk1(tx_pkt_avail, 1'b0);
		pop(4);
		repeat (4) @(negedge ref_clk);
		chk1(tx_pkt_avail, 1'b0);
		pop(3);
		repeat (4) @(negedge ref_clk);
		chk1(tx_pkt_avail, 1'b1);
		pop(3);
	endtask
	task automatic over_scn;
		// room left for the six-word fragment that flow_scn sends
		tx_thresh_upper = 7'(ppb_pkg::TX_DEPTH - 6);
		sys.send_tx(66);
		chk1(tx_pkt_avail, 1'b0);
		tx_out_ready = 1'b1;
		repeat (200) @(negedge ref_clk);
		tx_out_ready = 1'b0;
		chk1(tx_out_valid, 1'b0);
		chk1(tx_pkt_avail, 1'b1);
		// one word waits at the core side, 64 fill the buffer, one drops
		check(34'(ovf_count), 34'(1));
	endtask
	task automatic cmp_q(input int rn, input int pn);
		for (int t = 0; sys.rxq.size() < rn || sys.rpq.size() < pn; t++)
		begin
			if (t == 3000)
				hang();
			@(negedge ref_clk);
		end
		repeat (40) @(negedge ref_clk);
		check(34'(sys.rxq.size()), 34'(rn));
		check(34'(sys.rpq.size()), 34'(pn));
		for (int i = 0; i < rn; i++)
			check(sys.rxq[i], {i % 3 == 0, i % 3 == 2, 32'(32'h100 + i)});
		for (int i = 0; i < pn; i++)
			check(sys.rpq[i], {i % 2 == 0, i % 2 == 1, 24'h0, 8'(8'h40 + i)});
	endtask
	task automatic reg_scn;
		registered_mode = 1'b1;
		sys.en_pat = 8'hb4;
		repeat (2) @(negedge ref_clk);
		chk1(rx_cell_avail_oe, 1'b1);
		chk1(rep_cell_avail_oe, 1'b1);
		chk1(rep_cell_avail, 1'b0);
		rx_lim = 12;
		rp_lim = 8;
		repeat (20) @(negedge ref_clk);
		chk1(rx_cell_avail, 1'b1);
		cmp_q(12, 8);
	endtask
	task automatic reset_scn;
		sys.en_pat = 8'h00;
		rx_lim = 40;
		repeat (50) @(negedge ref_clk);
		rst_b = 1'b0;
		#1;
		chk1(rx_oe, 1'b0);
		chk1(rep_oe, 1'b0);
		chk1(tx_pkt_avail_oe, 1'b0);
		chk1(rx_valid, 1'b0);
		repeat (3) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk1(rx_oe, 1'b1);
	endtask
	initial
	begin
		rst_b = 1'b0;
		registered_mode = 1'b0;
		tx_out_ready = 1'b0;
		tx_thresh_upper = 7'h08;
		tx_thresh_lower = 7'h04;
		repeat (3) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (8) @(negedge ref_clk);
		flow_scn();
		over_scn();
		rx_lim = 6;
		rp_lim = 4;
		cmp_q(6, 4);
		reg_scn();
		reset_scn();
		print_verdict();
	end
endmodule
`default_nettype wire
